// *** logic/ao_bank_update_control.sv ***
// analog output bank update control with wishbone register slave
// assumes classic wishbone master on core_clk, pins synchronous to core_clk
//
// Summary of operation
// - channels are grouped in banks of four, each bank feeding one converter.
// - every bank has a selector between the waveform update clock and software convert.
// - in timed generation an update clock pulse with a frame ready loads every clock-sourced bank; with none ready it flags underflow.
// - a software convert updates every bank named in it that is software sourced.
// - a sample buffer feeds the converters so playback needs no host action per sample.
// - 32 or 64 channels are supported, all timed from one common clock.
// - a function line set as input may supply any timing signal or counter input.
// - a function line set as output may carry an internal timing signal or counter output.
// - each shared terminal is set on its own as function line or digital line.
// - each digital line of ports zero, one and two has its own direction.
// - digital lines of ports one and two move only under software control.
// - a bank serves only one generation type, software or timed, at a time.
// - a software convert updates a bank's four channels together, one signal per bank.
// - at most one timed generation runs at any time.
module ao_bank_update_control
    import ao_pkg::*;
#(
    parameter int NUM_CH  = 32,
    parameter int NL      = 16,
    parameter int FIFO_AW = 10
)
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic [7:0]               wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    input  wire logic                     wb_we_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    output logic                          wb_ack_o,
    output logic      [NUM_CH*DATA_W-1:0] dac_data,
    output logic      [NUM_CH/4-1:0]      dac_update,
    output logic                          waveform_update_clock,
    input  wire logic [P0_W-1:0]          port_zero_line_in,
    output logic      [P0_W-1:0]          port_zero_line_out,
    output logic      [P0_W-1:0]          port_zero_line_oe,
    input  wire logic [NL-1:0]            programmable_function_line_in,
    output logic      [NL-1:0]            programmable_function_line_out,
    output logic      [NL-1:0]            programmable_function_line_oe,
    input  wire logic                     counter_out,
    input  wire logic                     di_timing_int,
    input  wire logic                     do_timing_int,
    output logic                          counter_in,
    output logic                          di_timing_ext,
    output logic                          do_timing_ext
);

    localparam int NB    = NUM_CH / BANK_SIZE;
    localparam int DIO_W = P0_W + NL;
    localparam int DEPTH = 2 ** FIFO_AW;

    typedef struct packed {
        logic                           ack;
        logic [31:0]                    rdata;
        logic                           run;
        logic [15:0]                    div;
        logic [15:0]                    div_cnt;
        logic [NB-1:0]                  bank_src;
        logic [NB-1:0]                  upd;
        logic [NL-1:0]                  fn_en;
        logic [NL-1:0]                  fn_dir;
        logic [2*NL-1:0]                route;
        logic [31:0]                    tsrc;
        logic [DIO_W-1:0]               dio_dir;
        logic [DIO_W-1:0]               dio_out;
        logic [CH_W-1:0]                stage_ch;
        logic [NUM_CH-1:0][DATA_W-1:0]  sw_stage;
        logic [NUM_CH-1:0][DATA_W-1:0]  hw_stage;
        logic [NUM_CH-1:0][DATA_W-1:0]  dac;
        eng_state_t                     eng;
        logic [FIFO_AW:0]               count;
        logic [FIFO_AW-1:0]             wr_ptr;
        logic [FIFO_AW-1:0]             rd_ptr;
        logic                           underflow;
        logic                           overflow;
        logic                           ext_q;
        logic                           upd_clk;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic              req;
    logic              wr;
    logic              full;
    logic              push;
    logic              pop;
    logic              tick;
    logic              int_tick;
    logic              ext_clk;
    logic [31:0]       ram_q;
    logic [NB-1:0]     sw_mask;
    logic [NL-1:0]     line_dio_in;

    // byte-lane merge for register writes
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    assign req      = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign wr       = req & wb_we_i;
    assign full     = st_r.count == (FIFO_AW+1)'(DEPTH);
    assign push     = wr && wb_adr_i == OFS_FIFO_DATA && !full;
    assign int_tick = st_r.run && st_r.div_cnt == 16'h0000;
    // one common update clock for every channel, internal or from a line
    assign tick     = st_r.run && (st_r.tsrc[TS_CLK_EXT_BIT] ?
                      (ext_clk & ~st_r.ext_q) : int_tick);
    // software convert only reaches software-sourced banks
    assign sw_mask  = (wr && wb_adr_i == OFS_SW_CONVERT) ?
                      (wb_dat_i[NB-1:0] & ~st_r.bank_src) : '0;
    assign pop      = st_r.eng == ENG_FILL && st_r.run
                      && st_r.count != '0;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.ack   = req;
        st_nxt.upd   = '0;
        st_nxt.ext_q = ext_clk;
        st_nxt.upd_clk = tick;

        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                OFS_CTRL:       st_nxt.rdata = 32'(st_r.run);
                OFS_BANK_SRC:   st_nxt.rdata = 32'(st_r.bank_src);
                OFS_STAGE_CH:   st_nxt.rdata = 32'(st_r.stage_ch);
                OFS_STATUS:
                begin
                    st_nxt.rdata = '0;
                    st_nxt.rdata[ST_UNDERFLOW] = st_r.underflow;
                    st_nxt.rdata[ST_OVERFLOW]  = st_r.overflow;
                    st_nxt.rdata[ST_EMPTY]     = st_r.count == '0;
                    st_nxt.rdata[ST_FULL]      = full;
                    st_nxt.rdata[ST_FRAME]     = st_r.eng == ENG_READY;
                    st_nxt.rdata[ST_LEVEL_LSB +: FIFO_AW+1] = st_r.count;
                end
                OFS_LINE_FN:    st_nxt.rdata = 32'(st_r.fn_en);
                OFS_LINE_DIR:   st_nxt.rdata = 32'(st_r.fn_dir);
                OFS_LINE_ROUTE: st_nxt.rdata = 32'(st_r.route);
                OFS_TIMING_SRC: st_nxt.rdata = st_r.tsrc;
                OFS_DIO_DIR:    st_nxt.rdata = 32'(st_r.dio_dir);
                OFS_DIO_OUT:    st_nxt.rdata = 32'(st_r.dio_out);
                OFS_DIO_IN:     st_nxt.rdata = 32'({line_dio_in, port_zero_line_in});
                OFS_CLK_DIV:    st_nxt.rdata = 32'(st_r.div);
                default:        st_nxt.rdata = '0;
            endcase
        end

        if (wr)
        begin
            case (wb_adr_i)
                OFS_CTRL:
                    st_nxt.run = wb_sel_i[0] ? wb_dat_i[CTRL_RUN_BIT] : st_r.run;
                OFS_BANK_SRC:
                    st_nxt.bank_src = NB'(wmerge(32'(st_r.bank_src), wb_dat_i, wb_sel_i));
                OFS_STAGE_CH:
                    st_nxt.stage_ch = wb_dat_i[CH_W-1:0];
                OFS_STAGE_DATA:
                begin
                    if ({1'b0, st_r.stage_ch} < (CH_W+1)'(NUM_CH))
                    begin
                        st_nxt.sw_stage[st_r.stage_ch] = wb_dat_i[DATA_W-1:0];
                    end
                end
                OFS_FIFO_DATA:
                begin
                    if (full)
                    begin
                        st_nxt.overflow = 1'b1;
                    end
                end
                OFS_STATUS:
                begin
                    if (wb_dat_i[ST_UNDERFLOW])
                    begin
                        st_nxt.underflow = 1'b0;
                    end
                    if (wb_dat_i[ST_OVERFLOW] && !(full && push))
                    begin
                        st_nxt.overflow = 1'b0;
                    end
                end
                OFS_LINE_FN:
                    st_nxt.fn_en = NL'(wmerge(32'(st_r.fn_en), wb_dat_i, wb_sel_i));
                OFS_LINE_DIR:
                    st_nxt.fn_dir = NL'(wmerge(32'(st_r.fn_dir), wb_dat_i, wb_sel_i));
                OFS_LINE_ROUTE:
                    st_nxt.route = (2*NL)'(wmerge(32'(st_r.route), wb_dat_i, wb_sel_i));
                OFS_TIMING_SRC:
                    st_nxt.tsrc = wmerge(st_r.tsrc, wb_dat_i, wb_sel_i);
                OFS_DIO_DIR:
                    st_nxt.dio_dir = DIO_W'(wmerge(32'(st_r.dio_dir), wb_dat_i, wb_sel_i));
                OFS_DIO_OUT:
                    st_nxt.dio_out = DIO_W'(wmerge(32'(st_r.dio_out), wb_dat_i, wb_sel_i));
                OFS_CLK_DIV:
                    st_nxt.div = 16'(wmerge(32'(st_r.div), wb_dat_i, wb_sel_i));
                default:
                    st_nxt.div = st_r.div;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // internal update clock divider
        if (!st_r.run || int_tick)
        begin
            st_nxt.div_cnt = st_r.div;
        end
        else
        begin
            st_nxt.div_cnt = st_r.div_cnt - 16'h0001;
        end

        // software convert: whole bank at once, per-bank strobe
        for (int b = 0; b < NB; b++)
        begin
            if (sw_mask[b])
            begin
                st_nxt.dac[b*BANK_SIZE +: BANK_SIZE] =
                    st_r.sw_stage[b*BANK_SIZE +: BANK_SIZE];
                st_nxt.upd[b] = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // playback engine: drain buffer into frame, release frame on tick
        case (st_r.eng)
            ENG_FILL:
            begin
                if (pop)
                begin
                    st_nxt.eng = ENG_WAIT;
                end
            end
            ENG_WAIT:
            begin
                if (32'(ram_q[SMP_CH_LSB +: CH_W]) < NUM_CH)
                begin
                    st_nxt.hw_stage[ram_q[SMP_CH_LSB +: CH_W]] = ram_q[DATA_W-1:0];
                end
                st_nxt.eng = ram_q[SMP_EOF_BIT] ? ENG_READY : ENG_FILL;
            end
            ENG_READY:
            begin
                if (tick)
                begin
                    for (int b = 0; b < NB; b++)
                    begin
                        if (st_r.bank_src[b])
                        begin
                            st_nxt.dac[b*BANK_SIZE +: BANK_SIZE] =
                                st_r.hw_stage[b*BANK_SIZE +: BANK_SIZE];
                            st_nxt.upd[b] = 1'b1;
                        end
                    end
                    st_nxt.eng = ENG_FILL;
                end
            end
            default:
                st_nxt.eng = ENG_FILL;
        endcase

        // set wins over a clear in the same cycle
        if (tick && st_r.eng != ENG_READY)
        begin
            st_nxt.underflow = 1'b1;
        end

        st_nxt.count  = (FIFO_AW+1)'(st_r.count + (FIFO_AW+1)'(push)
                        - (FIFO_AW+1)'(pop));
        st_nxt.wr_ptr = st_r.wr_ptr + FIFO_AW'(push);
        st_nxt.rd_ptr = st_r.rd_ptr + FIFO_AW'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r          <= '0;
            st_r.div      <= CLK_DIV_RST;
            st_r.div_cnt  <= CLK_DIV_RST;
            st_r.eng      <= ENG_FILL;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    sample_ram #(
        .W  (32),
        .AW (FIFO_AW)
    ) u_ram (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (push),
        .wr_addr  (st_r.wr_ptr),
        .wr_data  (wb_dat_i),
        .rd_en    (pop),
        .rd_addr  (st_r.rd_ptr),
        .rd_data  (ram_q)
    );

    line_mux #(
        .NL (NL)
    ) u_mux (
        .line_in       (programmable_function_line_in),
        .fn_en         (st_r.fn_en),
        .fn_dir        (st_r.fn_dir),
        .route         (st_r.route),
        .dio_dir       (st_r.dio_dir[DIO_W-1:P0_W]),
        .dio_out       (st_r.dio_out[DIO_W-1:P0_W]),
        .tsrc          (st_r.tsrc),
        .upd_clk       (st_r.upd_clk),
        .counter_out   (counter_out),
        .di_timing_int (di_timing_int),
        .do_timing_int (do_timing_int),
        .line_out      (programmable_function_line_out),
        .line_oe       (programmable_function_line_oe),
        .dio_in        (line_dio_in),
        .ext_clk       (ext_clk),
        .counter_in    (counter_in),
        .di_timing_ext (di_timing_ext),
        .do_timing_ext (do_timing_ext)
    );

    assign wb_dat_o              = st_r.rdata;
    assign wb_ack_o              = st_r.ack;
    assign dac_data              = st_r.dac;
    assign dac_update            = st_r.upd;
    assign waveform_update_clock = st_r.upd_clk;
    assign port_zero_line_out    = st_r.dio_out[P0_W-1:0];
    assign port_zero_line_oe     = st_r.dio_dir[P0_W-1:0];

    ////////////////////////////////////////////////////////////////////////

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_dac_hold: assert property (st_r.upd == '0 |-> $stable(st_r.dac))
        else $error("converter data changed without update");

    a_sw_banks: assert property (sw_mask != '0 |=>
        (st_r.upd & ~$past(st_r.bank_src)) == $past(sw_mask))
        else $error("software convert did not update its banks");

    a_hw_banks: assert property (tick && st_r.eng == ENG_READY |=>
        (st_r.upd & $past(st_r.bank_src)) == $past(st_r.bank_src))
        else $error("update clock did not load timed banks");

    a_no_hw_update: assert property (!tick |=>
        (st_r.upd & $past(st_r.bank_src)) == '0)
        else $error("timed bank updated without clock");

    a_bank_exclusive: assert property (sw_mask == '0 |=>
        (st_r.upd & ~$past(st_r.bank_src)) == '0)
        else $error("software bank updated by update clock");

    a_fifo_level: assert property (st_r.count <= (FIFO_AW+1)'(DEPTH))
        else $error("sample buffer level out of range");

    a_fifo_underflow: assert property (tick && st_r.eng != ENG_READY |=>
        st_r.underflow)
        else $error("missed frame not flagged");

    a_fetch_run: assert property (pop |-> st_r.run ##1 st_r.eng == ENG_WAIT)
        else $error("buffer read outside a running generation");

    a_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle");

    a_port0_dir: assert property ($past(wr) && $past(wb_adr_i) == OFS_DIO_DIR
        && $past(wb_sel_i[0]) |-> port_zero_line_oe == $past(wb_dat_i[P0_W-1:0]))
        else $error("port zero direction not applied");

    c_sw_convert: cover property (sw_mask != '0 ##1 dac_update != '0);
    c_hw_update:  cover property (tick && st_r.eng == ENG_READY && st_r.bank_src != '0);
    c_underflow:  cover property (tick && st_r.eng != ENG_READY);
    c_fifo_full:  cover property (full);

endmodule

// *** shared/ao_pkg.sv ***
// constants, register map and types for the analog output update control
// assumes a 32-bit classic wishbone register bus with byte addresses
package ao_pkg;

    localparam int BANK_SIZE = 4;
    localparam int DATA_W    = 16;
    localparam int CH_W      = 6;
    localparam int P0_W      = 4;
    localparam int TS_SEL_W  = 4;

    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_BANK_SRC   = 8'h04;
    localparam logic [7:0] OFS_SW_CONVERT = 8'h08;
    localparam logic [7:0] OFS_STAGE_CH   = 8'h0c;
    localparam logic [7:0] OFS_STAGE_DATA = 8'h10;
    localparam logic [7:0] OFS_FIFO_DATA  = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;
    localparam logic [7:0] OFS_LINE_FN    = 8'h1c;
    localparam logic [7:0] OFS_LINE_DIR   = 8'h20;
    localparam logic [7:0] OFS_LINE_ROUTE = 8'h24;
    localparam logic [7:0] OFS_TIMING_SRC = 8'h28;
    localparam logic [7:0] OFS_DIO_DIR    = 8'h2c;
    localparam logic [7:0] OFS_DIO_OUT    = 8'h30;
    localparam logic [7:0] OFS_DIO_IN     = 8'h34;
    localparam logic [7:0] OFS_CLK_DIV    = 8'h38;

    localparam int CTRL_RUN_BIT   = 0;
    localparam int ST_UNDERFLOW   = 0;
    localparam int ST_OVERFLOW    = 1;
    localparam int ST_EMPTY       = 2;
    localparam int ST_FULL        = 3;
    localparam int ST_FRAME       = 4;
    localparam int ST_LEVEL_LSB   = 16;
    localparam int SMP_EOF_BIT    = 31;
    localparam int SMP_CH_LSB     = 16;
    localparam int TS_CLK_LSB     = 0;
    localparam int TS_CLK_EXT_BIT = 7;
    localparam int TS_CNT_LSB     = 8;
    localparam int TS_DI_LSB      = 16;
    localparam int TS_DO_LSB      = 24;

    localparam logic [15:0] CLK_DIV_RST = 16'h03e7;

    typedef enum logic [1:0]
    {
        ENG_FILL  = 2'b00,
        ENG_WAIT  = 2'b01,
        ENG_READY = 2'b10
    } eng_state_t;

    typedef enum logic [1:0]
    {
        ROUTE_UPDATE_CLK = 2'b00,
        ROUTE_COUNTER    = 2'b01,
        ROUTE_DI_TIMING  = 2'b10,
        ROUTE_DO_TIMING  = 2'b11
    } route_t;

endpackage

// *** logic/sample_ram.sv ***
// storage of the output sample buffer, one write and one registered read port
// assumes the caller keeps its own pointers and level
module sample_ram
#(
    parameter int W  = 32,
    parameter int AW = 10
)
(
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    logic [W-1:0] mem [2**AW];

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
        end
        else if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// *** logic/line_mux.sv ***
// shared terminal multiplexer: function line or digital line per terminal
// assumes line inputs are synchronous to core_clk
module line_mux
    import ao_pkg::*;
#(
    parameter int NL = 16
)
(
    input  wire logic [NL-1:0]       line_in,
    input  wire logic [NL-1:0]       fn_en,
    input  wire logic [NL-1:0]       fn_dir,
    input  wire logic [2*NL-1:0]     route,
    input  wire logic [NL-1:0]       dio_dir,
    input  wire logic [NL-1:0]       dio_out,
    input  wire logic [31:0]         tsrc,
    input  wire logic                upd_clk,
    input  wire logic                counter_out,
    input  wire logic                di_timing_int,
    input  wire logic                do_timing_int,
    output logic      [NL-1:0]       line_out,
    output logic      [NL-1:0]       line_oe,
    output logic      [NL-1:0]       dio_in,
    output logic                     ext_clk,
    output logic                     counter_in,
    output logic                     di_timing_ext,
    output logic                     do_timing_ext
);

    // only a terminal set up as function input may act as a source
    function automatic logic pick(input logic [TS_SEL_W-1:0] idx,
                                  input logic [NL-1:0] lin,
                                  input logic [NL-1:0] en,
                                  input logic [NL-1:0] dir);
        logic r;
        r = 1'b0;
        if (32'(idx) < NL)
        begin
            r = lin[idx] & en[idx] & ~dir[idx];
        end
        return r;
    endfunction

    assign ext_clk       = pick(tsrc[TS_CLK_LSB +: TS_SEL_W], line_in, fn_en, fn_dir);
    assign counter_in    = pick(tsrc[TS_CNT_LSB +: TS_SEL_W], line_in, fn_en, fn_dir);
    assign di_timing_ext = pick(tsrc[TS_DI_LSB +: TS_SEL_W], line_in, fn_en, fn_dir);
    assign do_timing_ext = pick(tsrc[TS_DO_LSB +: TS_SEL_W], line_in, fn_en, fn_dir);

    // digital lines only reflect software settings, never timed transfers
    assign dio_in = line_in & ~fn_en;

    for (genvar i = 0; i < NL; i++)
    begin : g_line
        logic fn_src;
        always_comb
        begin
            case (route_t'(route[2*i +: 2]))
                ROUTE_UPDATE_CLK: fn_src = upd_clk;
                ROUTE_COUNTER:    fn_src = counter_out;
                ROUTE_DI_TIMING:  fn_src = di_timing_int;
                ROUTE_DO_TIMING:  fn_src = do_timing_int;
                default:          fn_src = 1'b0;
            endcase
        end
        assign line_out[i] = fn_en[i] ? fn_src : dio_out[i];
        assign line_oe[i]  = fn_en[i] ? fn_dir[i] : dio_dir[i];
    end

endmodule

// *** testbench/host_feeder.sv ***
// host model: wishbone master that loads registers and feeds samples
// assumes the slave answers with a one-cycle ack; sel is tied by the bench
module host_feeder
(
    input  wire logic        core_clk,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    output logic      [7:0]  wb_adr_i,
    output logic      [31:0] wb_dat_i,
    output logic             wb_we_i,
    output logic             wb_cyc_i,
    output logic             wb_stb_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rd_r;
    initial {wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    // held until ack is sampled, then one idle cycle
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge core_clk);
        {wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} <= {a, d, w, 2'b11};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd_r = wb_dat_o;
        {wb_we_i, wb_cyc_i, wb_stb_i} <= 3'b000;
        @(posedge core_clk);
    endtask
endmodule

// *** testbench/ao_bank_update_control_tb_top.sv ***
// bench for the bank update control: register tasks and directed checks
// assumes the host model drives the wishbone side
module ao_bank_update_control_tb_top
    import ao_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         core_clk = 1'b0, rst_n = 1'b0, counter_out = 1'b0;
    logic         wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, waveform_update_clock;
    logic         counter_in, di_timing_ext, do_timing_ext;
    logic [7:0]   wb_adr_i, dac_update, upd_seen = 8'h0;
    logic [31:0]  wb_dat_i, wb_dat_o;
    logic [3:0]   port_zero_line_in = 4'h0, port_zero_line_out, port_zero_line_oe;
    logic [15:0]  pf_in = 16'h0, pf_out, pf_oe;
    logic [511:0] dac_data;
    int           err_total = 0, comparisons = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) upd_seen <= upd_seen | dac_update;
    host_feeder h
    (
        .core_clk, .wb_ack_o, .wb_dat_o, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_cyc_i, .wb_stb_i
    );
    ao_bank_update_control uut
    (
        .core_clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i(4'hf),
        .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dac_data, .dac_update, .waveform_update_clock,
        .port_zero_line_in, .port_zero_line_out, .port_zero_line_oe,
        .programmable_function_line_in(pf_in), .programmable_function_line_out(pf_out),
        .programmable_function_line_oe(pf_oe), .counter_out, .di_timing_int(1'b0),
        .do_timing_int(1'b0), .counter_in, .di_timing_ext, .do_timing_ext
    );
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
            $display("CHECK FAILED at %0t: got %h exp %h (%0d)", $time, got, exp, ++err_total);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        h.xfer(a, d, 1'b1);
    endtask
    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #50us;
        err_total++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        chk(|dac_data, 1'b0);
        wr(OFS_BANK_SRC, 32'h0);
        for (int c = 4; c < 8; c++)
        begin
            wr(OFS_STAGE_CH, c);
            wr(OFS_STAGE_DATA, 32'h1230 + c);
        end
        chk(dac_data[127:64], 64'h0);
        wr(OFS_SW_CONVERT, 32'h2);
        chk(dac_data[127:64], 64'h1237_1236_1235_1234);
        chk(upd_seen, 8'h02);
        wr(OFS_BANK_SRC, 32'h2);
        wr(OFS_STAGE_CH, 32'h4);
        wr(OFS_STAGE_DATA, 32'h0bad);
        wr(OFS_SW_CONVERT, 32'h3);
        chk(dac_data[79:64], 16'h1234);
        for (int c = 4; c < 8; c++)
            wr(OFS_FIFO_DATA, {c == 7, 9'h0, 6'(c), 16'h5670 + 16'(c)});
        wr(OFS_CLK_DIV, 32'h3);
        wr(OFS_CTRL, 32'h1);
        for (int i = 0; i < 60 && dac_update[1] !== 1'b1; i++) @(posedge core_clk);
        chk(dac_data[127:64], 64'h5677_5676_5675_5674);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_LINE_FN, 32'hc);
        wr(OFS_LINE_DIR, 32'h8);
        wr(OFS_LINE_ROUTE, 32'h40);
        wr(OFS_TIMING_SRC, 32'h200);
        wr(OFS_DIO_DIR, 32'h11);
        wr(OFS_DIO_OUT, 32'h11);
        pf_in <= 16'h0006;
        counter_out <= 1'b1;
        port_zero_line_in <= 4'ha;
        @(posedge core_clk);
        chk({counter_in, pf_out[3], pf_oe[3]}, 3'b111);
        chk({port_zero_line_out[0], port_zero_line_oe[1:0], pf_out[0], pf_oe[0]}, 5'h17);
        h.xfer(OFS_DIO_IN, 32'h0, 1'b0);
        chk(h.rd_r, 32'h2a);
        h.xfer(8'hfc, 32'h0, 1'b0);
        chk(h.rd_r, 32'h0);
        end_sim();
    end
endmodule
